// ==== ebw_bus.sv ====
// external bus sequencer with software wait states and address visibility
`timescale 1ns/1ns
module ebw_bus
   import ebw_pkg::*;
(
   // clocking
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // cpu side requests, held until acknowledged
   input  wire ebw_req_s    wr_req,
   input  wire ebw_req_s    rd_req,
   input  wire ebw_req_s    pf_req,
   input  wire logic [15:0] pc_addr,
   input  wire logic [7:0]  global_window_size,
   output logic      [2:0]  ack,
   output logic      [15:0] rdata,
   output logic             rdata_valid,
   output logic      [3:0]  wait_state_control,
   // external pins
   output logic      [15:0] addr_out,
   output logic      [15:0] data_out,
   output logic             data_oe_n,
   input  wire logic [15:0] data_in,
   output logic             rw,
   output logic             bus_strobe_n,
   output logic             rd_n,
   output logic             we_n,
   output logic             program_space_select_n,
   output logic             data_space_select_n,
   output logic             io_space_select_n,
   output logic             global_bus_request_n,
   input  wire logic        ready
);

   ebw_core_s   r;
   ebw_core_s   n;
   logic        ready_s;
   logic [15:0] din_s;
   logic        fin;

   // data is synchronised alongside ready so the word captured is the one
   // present when the device raised ready
   ebw_sync #(.W(17)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .d    ({ready, data_in}),
      .q    ({ready_s, din_s})
   );

   function automatic logic sw_wait(input ebw_kind_e k, input logic io, input logic [3:0] w);
      logic b;
      b = w[EBW_DSW_BIT];
      if (k == K_PF) begin
         b = w[EBW_PSW_BIT];
      end else if (io) begin
         b = w[EBW_ISW_BIT];
      end
      return b;
   endfunction : sw_wait

   function automatic logic in_global(input logic io, input logic [15:0] a,
                                      input logic [7:0] g);
      return !io && a[15] && (g != 8'h00) && (a[15:8] >= g);
   endfunction : in_global

   always_comb begin
      ebw_kind_e k;
      ebw_req_s  q;
      logic      ext;
      k      = K_PF;
      q      = pf_req;
      ext    = 1'b0;
      n      = r;
      n.rdv  = 1'b0;
      ack    = 3'h0;
      fin    = 1'b0;
      case (r.st)
         ST_IDLE: begin
            fin = 1'b1;
         end
         ST_WR1: begin
            n.st = ST_XFER;
         end
         ST_SWW: begin
            n.st = ST_XFER;
         end
         ST_XFER: begin
            if (ready_s) begin
               fin            = 1'b1;
               ack[r.kind]    = 1'b1;
               if (r.kind != K_WR) begin
                  n.rdata = din_s;
                  n.rdv   = 1'b1;
               end
            end
         end
         ST_REG: begin
            if (ready_s) begin
               fin         = 1'b1;
               ack[r.kind] = 1'b1;
               if (r.kind == K_WR) begin
                  n.wsc = r.pins.dout[EBW_WSC_W-1:0];
               end else begin
                  n.rdata = {EBW_WSC_RSVD, r.wsc};
                  n.rdv   = 1'b1;
               end
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      if (fin) begin
         n.st = ST_IDLE;
         // the request being acknowledged is still held this cycle, so it is
         // masked out to avoid running the same access twice
         q.valid = pf_req.valid && !ack[K_PF];
         // writes win over reads, reads over fetches
         if (wr_req.valid && !ack[K_WR]) begin
            k = K_WR;
            q = wr_req;
         end else if (rd_req.valid && !ack[K_RD]) begin
            k = K_RD;
            q = rd_req;
         end
         if (q.valid) begin
            n.kind      = k;
            n.io        = q.io && (k != K_PF);
            n.glob      = (k != K_PF) && in_global(q.io, q.addr, global_window_size);
            n.pins.addr = q.addr;
            n.pins.dout = q.wdata;
            if (n.io && q.addr == EBW_WSC_ADDR) begin
               n.st = ST_REG;
            end else if (k == K_WR) begin
               n.st = ST_WR1;
            end else if (sw_wait(k, n.io, n.wsc)) begin
               n.st = ST_SWW;
            end else begin
               n.st = ST_XFER;
            end
         end
      end
      ext           = (n.st == ST_WR1) || (n.st == ST_SWW) || (n.st == ST_XFER);
      n.pins.stb_n  = !ext;
      n.pins.rw     = !(ext && n.kind == K_WR);
      n.pins.rd_n   = !(ext && n.kind != K_WR);
      n.pins.we_n   = !(n.st == ST_XFER && n.kind == K_WR);
      n.pins.oe_n   = !(ext && n.kind == K_WR);
      n.pins.psel_n = !(ext && n.kind == K_PF);
      n.pins.dsel_n = !(ext && n.kind != K_PF && !n.io);
      n.pins.isel_n = !(ext && n.io);
      n.pins.greq_n = !(ext && n.glob);
      // visibility only changes the address; strobes above stay high when idle
      if (n.st == ST_IDLE && n.wsc[EBW_VIS_BIT]) begin
         n.pins.addr = pc_addr;
      end
      if (!ce) begin
         ack = 3'h0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r                <= '0;
         r.st             <= ST_IDLE;
         r.kind           <= K_PF;
         r.wsc            <= EBW_WSC_RESET;
         r.pins.stb_n     <= 1'b1;
         r.pins.rd_n      <= 1'b1;
         r.pins.we_n      <= 1'b1;
         r.pins.rw        <= 1'b1;
         r.pins.psel_n    <= 1'b1;
         r.pins.dsel_n    <= 1'b1;
         r.pins.isel_n    <= 1'b1;
         r.pins.greq_n    <= 1'b1;
         r.pins.oe_n      <= 1'b1;
      end else if (ce) begin
         r <= n;
      end
   end

   assign rdata                  = r.rdata;
   assign rdata_valid            = r.rdv;
   assign wait_state_control     = r.wsc;
   assign addr_out               = r.pins.addr;
   assign data_out               = r.pins.dout;
   assign data_oe_n              = r.pins.oe_n;
   assign rw                     = r.pins.rw;
   assign bus_strobe_n           = r.pins.stb_n;
   assign rd_n                   = r.pins.rd_n;
   assign we_n                   = r.pins.we_n;
   assign program_space_select_n = r.pins.psel_n;
   assign data_space_select_n    = r.pins.dsel_n;
   assign io_space_select_n      = r.pins.isel_n;
   assign global_bus_request_n   = r.pins.greq_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_wsetup;
      !bus_strobe_n && we_n && !rw;
   endsequence

   sequence s_wstrobe;
      !bus_strobe_n && !we_n && !rw;
   endsequence

   property p_rw;
      (!bus_strobe_n && r.kind == K_WR) |-> !rw;
   endproperty
   a_rw: assert property (p_rw) else $error("direction wrong on write");

   property p_stb;
      (!rd_n || !we_n) |-> !bus_strobe_n && (rd_n != we_n);
   endproperty
   a_stb: assert property (p_stb) else $error("strobe missing or both strobes low");

   property p_rdn;
      (!bus_strobe_n && rw) |-> !rd_n && we_n && data_oe_n;
   endproperty
   a_rdn: assert property (p_rdn) else $error("read strobe wrong");

   property p_stall;
      (ce && r.st == ST_XFER && !ready_s) |=> r.st == ST_XFER && !bus_strobe_n;
   endproperty
   a_stall: assert property (p_stall) else $error("access ended without ready");

   property p_zero;
      (r.st == ST_XFER && r.kind == K_RD && ready_s && ce) |-> ack[K_RD] ##1 rdata_valid;
   endproperty
   a_zero: assert property (p_zero) else $error("read not completed on ready");

   property p_wr2;
      (ce && r.st == ST_WR1) |-> s_wsetup ##1 s_wstrobe;
   endproperty
   a_wr2: assert property (p_wr2) else $error("write setup cycle missing");

   property p_write;
      ($fell(we_n)) |-> $past(!bus_strobe_n && we_n && !rw);
   endproperty
   a_write: assert property (p_write) else $error("write shorter than two cycles");

   property p_sww;
      (ce && r.st == ST_SWW) |-> !ack[K_RD] && !ack[K_PF] ##1 r.st == ST_XFER;
   endproperty
   a_sww: assert property (p_sww) else $error("software wait not one cycle");

   property p_greq;
      (!bus_strobe_n && r.glob) |-> !global_bus_request_n && rw == (r.kind != K_WR);
   endproperty
   a_greq: assert property (p_greq) else $error("bus request missing");

   // sampled rstn keeps the attempt at the releasing edge out, where the
   // register still takes its reset branch
   property p_vis;
      (rstn && ce && n.st == ST_IDLE && n.wsc[EBW_VIS_BIT])
         |=> addr_out == $past(pc_addr) && bus_strobe_n && rd_n && we_n;
   endproperty
   a_vis: assert property (p_vis) else $error("visibility output wrong");

   property p_prio;
      (ce && fin && wr_req.valid && !ack[K_WR] && (rd_req.valid || pf_req.valid))
         |=> r.kind == K_WR;
   endproperty
   a_prio: assert property (p_prio) else $error("write not served first");

   property p_rsvd;
      (ce && r.st == ST_REG && ready_s && r.kind == K_RD) |=> rdata[15:4] == EBW_WSC_RSVD;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

endmodule : ebw_bus

// ==== ebw_pkg.sv ====
// constants, types and state layout of the external bus wait-state interface
// Notes on behaviour
// - a direction output tells read from write on every external cycle.
// - an active-low strobe frames every external cycle in every space.
// - separate active-low read strobe and write enable carry each cycle's timing.
// - a slow device holds ready low; the access and execution stall until high.
// - data accesses in the global window assert the bus request from their start.
// - reads finish with no wait state when no software wait and ready high.
// - every external write takes at least two machine cycles.
// - waits come in whole cycles; ready alone may extend without limit.
// - a set space wait bit adds one wait state to reads and fetches regardless of ready; writes ignore it.
// - control bits: program 0, data 1, I/O 2, visibility 3; 15..4 read zero.
// - visibility puts the program address on an idle bus, without wait states.
// - reset sets all four control bits to one.
// - the control register sits at the top address of I/O space.
// - same-cycle contenders go write first, then read, then program fetch.
// - space selects for program, data and I/O with 16-bit address and data.
package ebw_pkg;

   localparam logic [15:0] EBW_WSC_ADDR   = 16'hFFFF;
   localparam int          EBW_WSC_W      = 4;
   localparam int          EBW_PSW_BIT    = 0;
   localparam int          EBW_DSW_BIT    = 1;
   localparam int          EBW_ISW_BIT    = 2;
   localparam int          EBW_VIS_BIT    = 3;
   localparam logic [3:0]  EBW_WSC_RESET  = 4'hF;
   localparam logic [11:0] EBW_WSC_RSVD   = 12'h000;
   localparam int          EBW_SYNC_DEPTH = 2;

   typedef enum logic [2:0] {ST_IDLE, ST_WR1, ST_SWW, ST_XFER, ST_REG} ebw_st_e;
   // kind value doubles as the index of the matching acknowledge bit
   typedef enum logic [1:0] {K_WR, K_RD, K_PF} ebw_kind_e;

   typedef struct packed {
      logic        valid;
      logic        io;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ebw_req_s;

   typedef struct packed {
      logic        stb_n;
      logic        rd_n;
      logic        we_n;
      logic        rw;
      logic        psel_n;
      logic        dsel_n;
      logic        isel_n;
      logic        greq_n;
      logic        oe_n;
      logic [15:0] addr;
      logic [15:0] dout;
   } ebw_pins_s;

   typedef struct packed {
      ebw_st_e     st;
      ebw_kind_e   kind;
      logic        io;
      logic        glob;
      logic [3:0]  wsc;
      ebw_pins_s   pins;
      logic [15:0] rdata;
      logic        rdv;
   } ebw_core_s;

endpackage : ebw_pkg

// ==== ebw_sync.sv ====
// two-stage synchroniser for the asynchronous bus inputs
`timescale 1ns/1ns
module ebw_sync
   import ebw_pkg::*;
#(
   parameter int W = 1
) (
   // clocking
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ebw_sync_s;

   ebw_sync_s r;
   ebw_sync_s n;

   always_comb begin
      n    = r;
      n.s1 = d;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

   assign q = r.s2;

endmodule : ebw_sync

// ==== ebw_mem.sv ====
// external memory and ready source on the far side of the bus sequencer
`timescale 1ns/1ns
module ebw_mem
   import ebw_pkg::*;
(
   // clocking
   input  wire logic        clk,
   input  wire logic        rstn,
   // bus pins
   input  wire logic [15:0] addr_out,
   input  wire logic [15:0] data_out,
   input  wire logic        data_oe_n,
   input  wire logic        bus_strobe_n,
   input  wire logic        rd_n,
   input  wire logic        we_n,
   output logic      [15:0] data_in,
   output logic             ready,
   // behaviour set by the bench
   input  wire logic        rdy_idle,
   input  wire logic [3:0]  lag
);
   logic [15:0] mem [256];
   logic [15:0] last_r;
   logic [3:0]  cnt_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r  <= 4'h0;
         last_r <= 16'h0000;
      end else begin
         cnt_r <= bus_strobe_n ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hF};
         if (!rd_n) begin
            last_r <= data_in;
         end
         if (!we_n && !data_oe_n) begin
            mem[addr_out[7:0]] <= data_out;
         end
      end
   end

   // a slow device lets ready rise only after lag strobe cycles
   assign ready   = bus_strobe_n ? rdy_idle : (cnt_r >= lag);
   // a released bus never repeats the last word, so stale captures show up
   assign data_in = !rd_n ? mem[addr_out[7:0]] : ~last_r;
endmodule : ebw_mem

// ==== test_ebw_bus.sv ====
// self-checking bench of the external bus wait-state sequencer
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_ebw_bus
   import ebw_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   ebw_req_s wr_req = '0;
   ebw_req_s rd_req = '0;
   ebw_req_s pf_req = '0;
   logic [15:0] pc_addr = 16'h1234;
   logic [7:0]  gws = 8'h00;
   logic [2:0]  ack;
   logic [15:0] rdata, addr_out, data_out, data_in;
   logic [3:0]  wait_state_control;
   logic        rdata_valid, data_oe_n, rw, bus_strobe_n, rd_n, we_n, ready;
   logic        psel_n, dsel_n, isel_n, greq_n;
   logic        rdy_idle = 1'b1;
   logic [3:0]  lag = 4'h0;
   int          err_count = 0;
   int          tests_run = 0;
   int          cyc;
   logic [15:0] rd;
   logic [3:0]  sel;
   logic [8:0]  log;

   always #5 clk = ~clk;

   ebw_bus u_ebw_bus (.clk(clk), .rstn(rstn), .ce(1'b1), .wr_req(wr_req), .rd_req(rd_req),
      .pf_req(pf_req), .pc_addr(pc_addr), .global_window_size(gws), .ack(ack),
      .rdata(rdata), .rdata_valid(rdata_valid), .wait_state_control(wait_state_control),
      .addr_out(addr_out), .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in),
      .rw(rw), .bus_strobe_n(bus_strobe_n), .rd_n(rd_n), .we_n(we_n),
      .program_space_select_n(psel_n), .data_space_select_n(dsel_n),
      .io_space_select_n(isel_n), .global_bus_request_n(greq_n), .ready(ready));

   ebw_mem u_ebw_mem (.clk(clk), .rstn(rstn), .addr_out(addr_out), .data_out(data_out),
      .data_oe_n(data_oe_n), .bus_strobe_n(bus_strobe_n), .rd_n(rd_n), .we_n(we_n),
      .data_in(data_in), .ready(ready), .rdy_idle(rdy_idle), .lag(lag));

   always @(posedge clk) begin
      if (rstn && !rd_n) `CHK({bus_strobe_n, rw}, 2'b01)
      if (rstn && !we_n) `CHK({bus_strobe_n, rw}, 2'b00)
   end

   task results;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   // sel collects bit0 program, bit1 data, bit2 io select and bit3 bus request
   task access(input int k, input logic io, input logic [15:0] a, input logic [15:0] wd);
      ebw_req_s r;
      r = '{1'b1, io, a, wd};
      sel = 4'h0;
      cyc = 0;
      @(posedge clk);
      if (k == 0) wr_req <= r; else if (k == 1) rd_req <= r; else pf_req <= r;
      do begin
         @(posedge clk);
         cyc++;
         sel |= {~greq_n, ~isel_n, ~dsel_n, ~psel_n};
      end while (ack[k] !== 1'b1 && cyc < 50);
      `CHK(ack[k], 1'b1)
      r.valid = 1'b0;
      if (k == 0) wr_req <= r; else if (k == 1) rd_req <= r; else pf_req <= r;
      @(posedge clk);
      rd = rdata;
      if (k != 0) `CHK(rdata_valid, 1'b1)
   endtask : access

   task set_wsc(input logic [15:0] v);
      access(0, 1'b1, 16'hFFFF, v);
   endtask : set_wsc

   task t_regs;
      `CHK(wait_state_control, 4'hF)
      `CHK(addr_out, 16'h1234)
      access(1, 1'b1, 16'hFFFF, 16'h0000);
      `CHK(rd, 16'h000F)
      `CHK(sel, 4'h0)
      set_wsc(16'hFFF2);
      `CHK(wait_state_control, 4'h2)
      access(1, 1'b1, 16'hFFFF, 16'h0000);
      `CHK(rd, 16'h0002)
   endtask : t_regs

   task t_zero;
      set_wsc(16'h0000);
      access(1, 1'b0, 16'h0040, 16'h0000);
      `CHK(cyc, 2)
      `CHK(sel, 4'h2)
      access(0, 1'b0, 16'h0123, 16'hA5C3);
      `CHK(cyc, 3)
      `CHK(sel, 4'h2)
   endtask : t_zero

   task t_wait;
      for (int s = 0; s < 3; s++) begin
         set_wsc(16'h0001 << s);
         for (int t = 0; t < 3; t++) begin
            access((t == 0) ? 2 : 1, t == 2, 16'h0010, 16'h0000);
            `CHK(cyc, (s == t) ? 3 : 2)
            `CHK(sel, 4'h1 << t)
         end
      end
   endtask : t_wait

   task t_slow;
      lag <= 4'h5;
      rdy_idle <= 1'b0;
      repeat (4) @(posedge clk);
      access(1, 1'b0, 16'h0123, 16'h0000);
      `CHK(cyc, 9)
      `CHK(rd, 16'hA5C3)
      rdy_idle <= 1'b1;
      lag <= 4'h0;
      repeat (4) @(posedge clk);
   endtask : t_slow

   task t_global;
      set_wsc(16'h0000);
      gws <= 8'h90;
      access(1, 1'b0, 16'h9100, 16'h0000);
      `CHK(sel, 4'hA)
      access(1, 1'b0, 16'h8100, 16'h0000);
      `CHK(sel, 4'h2)
   endtask : t_global

   // all three contenders raised together must finish write, read, fetch
   task t_order;
      log = 9'h000;
      @(posedge clk);
      wr_req <= '{1'b1, 1'b0, 16'h0050, 16'h1111};
      rd_req <= '{1'b1, 1'b0, 16'h0060, 16'h0000};
      pf_req <= '{1'b1, 1'b0, 16'h0070, 16'h0000};
      for (int i = 0; i < 30; i++) begin
         @(posedge clk);
         if (|ack) log = {log[5:0], ack};
         wr_req.valid <= wr_req.valid & ~ack[0];
         rd_req.valid <= rd_req.valid & ~ack[1];
         pf_req.valid <= pf_req.valid & ~ack[2];
      end
      `CHK(log, 9'h054)
   endtask : t_order

   task t_vis;
      set_wsc(16'h0008);
      pc_addr <= 16'h5A5A;
      repeat (3) @(posedge clk);
      `CHK(addr_out, 16'h5A5A)
      `CHK({bus_strobe_n, rd_n, we_n}, 3'h7)
      access(1, 1'b0, 16'h0040, 16'h0000);
      `CHK(cyc, 2)
      set_wsc(16'h0000);
   endtask : t_vis

   initial begin
      #100000;
      err_count++;
      results();
   end

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_zero();
      t_wait();
      t_slow();
      t_global();
      t_order();
      t_vis();
      results();
   end
endmodule : test_ebw_bus
